/* inc/fss_pkg.sv */
// fss_pkg: constants shared by the sweep sequencer device end and the host end.
// assumes both ends run from the same 40 MHz pclk and meet through fss_link_if.
package fss_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 25;   // pclk period
   localparam int LINK_HALF_NS    = 100;  // half period of the serial clock
   localparam int LINK_HALF_CYC   = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WORD_BITS       = 16;   // bits per serial command word
   // ----------------------------------------------------------------
   // command word decode
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_INCR_TAG   = 4'h1; // top four bits, increment count
   localparam logic [1:0] CMD_INTV_TAG   = 2'h1; // top two bits, step interval
   localparam logic [1:0] CMD_BURST_TAG  = 2'h2; // top two bits, burst duration; D13 is its select
   localparam int         COUNT_W        = 12;   // increment count width
   localparam int         TIME_W         = 11;   // interval and burst count width
   localparam int         TREG_W         = 14;   // interval and burst register width
   localparam int         TSEL_BIT       = 13;   // 1 = master clock periods
   localparam int         MULT_HI        = 12;   // multiplier field top bit
   localparam int         MULT_LO        = 11;   // multiplier field bottom bit
   // ----------------------------------------------------------------
   // time-base multipliers and reset values
   // ----------------------------------------------------------------
   localparam logic [8:0] MULT_X1   = 9'h001;
   localparam logic [8:0] MULT_X5   = 9'h005;
   localparam logic [8:0] MULT_X100 = 9'h064;
   localparam logic [8:0] MULT_X500 = 9'h1F4;
   localparam logic [COUNT_W-1:0] INCR_RESET = 12'h000;
   localparam logic [TREG_W-1:0]  TREG_RESET = 14'h0000;
   localparam int FREQ_W = 24;  // output frequency word
   localparam int STEP_W = 23;  // signed step value
   // ----------------------------------------------------------------
   // host register map (APB byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] HOST_CMD_OFS    = 8'h00; // write: word to send
   localparam logic [7:0] HOST_STATUS_OFS = 8'h04; // read: bit0 sender busy
   localparam logic [7:0] HOST_PINS_OFS   = 8'h08; // bit0 trigger, bit1 abort
endpackage

/* inc/fss_link_if.sv */
// fss_link_if: serial command link plus trigger and abort pins.
// assumes the host drives every wire; the device only listens.
`timescale 1ns/100ps
interface fss_link_if;
   logic link_sclk;          // serial clock, idles high
   logic link_sdata;         // serial data, changed on rising sclk
   logic frame_select_n;     // frame_select_input, low over a word
   logic trigger;            // sweep start and step pin
   logic abort;              // rising edge resets the sweep
   modport host (output link_sclk, output link_sdata, output frame_select_n,
                 output trigger, output abort);
   modport device (input link_sclk, input link_sdata, input frame_select_n,
                   input trigger, input abort);
endinterface

/* design/fss_host.sv */
// fss_host: APB slave that serialises command words and drives trigger/abort.
// assumes a single pclk domain; sclk is derived here by a divider.
`timescale 1ns/100ps
module fss_host #(
   parameter int HALF_CYC = fss_pkg::LINK_HALF_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   fss_link_if.host         link
);
   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic        busy_reg;
   logic [1:0]  pins_reg;
   wire         acc      = psel & penable & ~pready_reg;
   wire         hit_cmd  = (paddr == fss_pkg::HOST_CMD_OFS);
   wire         hit_stat = (paddr == fss_pkg::HOST_STATUS_OFS);
   wire         hit_pins = (paddr == fss_pkg::HOST_PINS_OFS);
   wire         mapped   = hit_cmd | hit_stat | hit_pins;
   wire         wr_now   = acc & pwrite & mapped;
   // a word written while busy is dropped: no queue by design
   wire         send_go  = wr_now & hit_cmd & ~busy_reg;
   wire [31:0]  rd_mux   = hit_stat ? {31'h00000000, busy_reg} :
                           hit_pins ? {30'h00000000, pins_reg} : 32'h00000000;

   // answer one cycle into the access phase, so all outputs are flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= acc;
         prdata_reg  <= (acc & ~pwrite) ? rd_mux : 32'h00000000;
         pslverr_reg <= acc & ~mapped;
      end
   end

   // pin levels, written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pins_reg <= 2'h0;
      else if (wr_now && hit_pins) pins_reg <= pwdata[1:0];
   end

   // ----------------------------------------------------------------
   // serial sender
   // ----------------------------------------------------------------
   logic [15:0] shift_reg;
   logic [4:0]  left_reg;
   logic [7:0]  div_reg;
   logic        sclk_reg;
   logic        fsn_reg;
   wire         half_tick = busy_reg & (div_reg == 8'(HALF_CYC - 1));

   // frame held low over all sixteen bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_reg <= 16'h0000;
         left_reg  <= 5'h00;
         div_reg   <= 8'h00;
         sclk_reg  <= 1'b1;
         fsn_reg   <= 1'b1;
         busy_reg  <= 1'b0;
      end else if (send_go) begin
         shift_reg <= pwdata[15:0];
         left_reg  <= 5'(fss_pkg::WORD_BITS);
         div_reg   <= 8'h00;
         fsn_reg   <= 1'b0;
         busy_reg  <= 1'b1;
      end else if (busy_reg) begin
         div_reg <= half_tick ? 8'h00 : div_reg + 8'h01;
         if (half_tick) begin
            sclk_reg <= ~sclk_reg;
            if (!sclk_reg) begin
               if (left_reg == 5'h01) begin
                  fsn_reg  <= 1'b1;
                  busy_reg <= 1'b0;
               end else begin
                  shift_reg <= {shift_reg[14:0], 1'b0};
               end
               left_reg <= left_reg - 5'h01;
            end
         end
      end
   end

   assign prdata              = prdata_reg;
   assign pready              = pready_reg;
   assign pslverr             = pslverr_reg;
   assign link.link_sclk      = sclk_reg;
   assign link.link_sdata     = shift_reg[15];
   assign link.frame_select_n = fsn_reg;
   assign link.trigger        = pins_reg[0];
   assign link.abort          = pins_reg[1];
endmodule // fss_host

/* design/fss_device.sv */
// fss_device: frequency sweep sequencer, the device end of the link.
// assumes link pins come from another domain and are synchronised here;
// start frequency, step value and control bits arrive as user-side levels.
`timescale 1ns/100ps

// Contract
// - top bits 0001 load increment count
// - host writes count from 2 to 4095
// - top bits 01 load interval; D13 selects
// - interval count is eleven unsigned bits
// - D12:D11 pick multiplier 1,5,100,500
// - top bits 100 load burst duration; code decodes only top bits 10, with D13 as its select
// - interval register wins select and multiplier
// - burst then midscale for interval rest
// - trigger rising edge starts sweep at start
// - auto mode times both from registers
// - external step per trigger, internal burst
// - ext-step internal burst uses burst timing bits
// - trigger high bursts, low listens, edge steps
// - fully external mode ignores timing bits
// - host sets continuous bit for no gaps
// - abort rising edge resets to midscale
// - sweep spans count plus one intervals
// - each step adds signed step value
// - burst source clear means register timing
// - host holds frame low over sixteen bits
module fss_device (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   fss_link_if.device                           link,
   input  wire logic [fss_pkg::FREQ_W-1:0]      start_frequency,
   input  wire logic [fss_pkg::STEP_W-1:0]      step_value,
   input  wire logic                            continuous_or_burst_select,
   input  wire logic                            burst_source_select,
   input  wire logic                            increment_source_select,
   input  wire logic                            wave_cycle_pulse,
   output logic      [fss_pkg::FREQ_W-1:0]      freq_word,
   output logic                                 wave_enable,
   output logic                                 sweep_busy,
   output logic                                 step_pulse
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic [4:0] sync3_reg;
   wire  [4:0] pins_in = {link.abort, link.trigger, link.frame_select_n,
                          link.link_sdata, link.link_sclk};

   // two flops per pin, a third copy only for edge finding
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 5'h07;
         sync2_reg <= 5'h07;
         sync3_reg <= 5'h07;
      end else begin
         sync1_reg <= pins_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   wire sclk_fall  = sync3_reg[0] & ~sync2_reg[0];
   wire sdata_s    = sync2_reg[1];
   wire frame_on   = ~sync2_reg[2];
   wire trig_s     = sync2_reg[3];
   wire trig_rise  = trig_s & ~sync3_reg[3];
   wire abort_rise = sync2_reg[4] & ~sync3_reg[4];

   // ----------------------------------------------------------------
   // serial word capture
   // ----------------------------------------------------------------
   logic [15:0] rx_reg;
   logic [4:0]  rx_cnt_reg;
   logic        word_ok_reg;
   wire  [15:0] rx_next = {rx_reg[14:0], sdata_s};

   // a short frame is thrown away when the frame line rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_reg      <= 16'h0000;
         rx_cnt_reg  <= 5'h00;
         word_ok_reg <= 1'b0;
      end else begin
         word_ok_reg <= 1'b0;
         if (!frame_on) begin
            rx_cnt_reg <= 5'h00;
         end else if (sclk_fall && rx_cnt_reg != 5'(fss_pkg::WORD_BITS)) begin
            rx_reg      <= rx_next;
            rx_cnt_reg  <= rx_cnt_reg + 5'h01;
            word_ok_reg <= (rx_cnt_reg == 5'(fss_pkg::WORD_BITS - 1));
         end
      end
   end

   // ----------------------------------------------------------------
   // command decode and setting registers
   // ----------------------------------------------------------------
   logic [fss_pkg::COUNT_W-1:0] increment_count_reg;
   logic [fss_pkg::TREG_W-1:0]  step_interval_reg;
   logic [fss_pkg::TREG_W-1:0]  burst_duration_reg;
   wire  ld_incr  = word_ok_reg & (rx_reg[15:12] == fss_pkg::CMD_INCR_TAG);
   wire  ld_intv  = word_ok_reg & (rx_reg[15:14] == fss_pkg::CMD_INTV_TAG);
   wire  ld_burst = word_ok_reg & (rx_reg[15:14] == fss_pkg::CMD_BURST_TAG);

   // other tags belong to registers kept outside this block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         increment_count_reg <= fss_pkg::INCR_RESET;
         step_interval_reg   <= fss_pkg::TREG_RESET;
         burst_duration_reg  <= fss_pkg::TREG_RESET;
      end else begin
         if (ld_incr)  increment_count_reg <= rx_reg[11:0];
         if (ld_intv)  step_interval_reg   <= rx_reg[fss_pkg::TREG_W-1:0];
         if (ld_burst) burst_duration_reg  <= rx_reg[fss_pkg::TREG_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // time base
   // ----------------------------------------------------------------
   // ext-step internal burst times from the burst register, else interval wins
   wire ext_inc   = increment_source_select;
   wire ext_burst = ext_inc & burst_source_select;
   wire use_burst_bits = ext_inc & ~burst_source_select;
   wire [fss_pkg::TREG_W-1:0] tsrc = use_burst_bits ? burst_duration_reg
                                                    : step_interval_reg;
   wire       clk_sel = tsrc[fss_pkg::TSEL_BIT];
   wire [1:0] msel    = tsrc[fss_pkg::MULT_HI:fss_pkg::MULT_LO];
   wire [8:0] mult    = (msel == 2'h0) ? fss_pkg::MULT_X1  :
                        (msel == 2'h1) ? fss_pkg::MULT_X5  :
                        (msel == 2'h2) ? fss_pkg::MULT_X100 : fss_pkg::MULT_X500;

   logic [8:0] pre_reg;
   wire        pre_wrap  = (pre_reg == mult - 9'h001);
   // fully external mode never looks at the time base
   wire        base_tick = ~ext_burst &
                           (clk_sel ? pre_wrap : wave_cycle_pulse);

   typedef enum logic [0:0] {FSS_IDLE, FSS_RUN} fss_state_t;
   fss_state_t state_reg;

   // ----------------------------------------------------------------
   // sweep sequencer
   // ----------------------------------------------------------------
   logic [fss_pkg::TIME_W-1:0]  time_reg;
   logic [fss_pkg::COUNT_W-1:0] step_cnt_reg;
   logic [fss_pkg::FREQ_W-1:0]  freq_reg;
   logic                        enable_reg;
   logic                        busy_reg;
   logic                        pulse_reg;

   wire [fss_pkg::TIME_W-1:0] intv_len  = step_interval_reg[fss_pkg::TIME_W-1:0];
   wire [fss_pkg::TIME_W-1:0] burst_len = burst_duration_reg[fss_pkg::TIME_W-1:0];
   wire [fss_pkg::TIME_W-1:0] time_inc  = time_reg + 11'h001;
   wire intv_end = base_tick & (time_inc >= intv_len);
   // auto steps on the time base, external ones on each trigger rise
   wire step_now = (state_reg == FSS_RUN) &
                   (ext_inc ? trig_rise : intv_end);

   // prescaler restarts with each step so every interval is whole
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre_reg <= 9'h000;
      else if (state_reg != FSS_RUN || step_now || pre_wrap) pre_reg <= 9'h000;
      else pre_reg <= pre_reg + 9'h001;
   end

   wire last     = (step_cnt_reg >= increment_count_reg);
   wire in_burst = (time_reg < burst_len);
   localparam int EXT_W = fss_pkg::FREQ_W - fss_pkg::STEP_W;
   wire step_sign = step_value[fss_pkg::STEP_W-1];
   wire [fss_pkg::FREQ_W-1:0] step_ext = {{EXT_W{step_sign}}, step_value};
   // output live: continuous, trigger level, or burst window
   wire live = continuous_or_burst_select ? 1'b1 :
               ext_burst ? trig_s :
               in_burst;

   // interval timer, held at the burst end while waiting for a trigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         time_reg <= 11'h000;
      end else if (state_reg != FSS_RUN || step_now) begin
         time_reg <= 11'h000;
      end else if (base_tick && !(ext_inc && !in_burst)) begin
         time_reg <= time_inc;
      end
   end

   // state, step counter and frequency; abort overrides everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= FSS_IDLE;
         step_cnt_reg <= 12'h000;
         freq_reg     <= 24'h000000;
         pulse_reg    <= 1'b0;
      end else begin
         pulse_reg <= 1'b0;
         if (abort_rise) begin
            state_reg <= FSS_IDLE;
         end else begin
            case (state_reg)
               FSS_IDLE: begin
                  if (trig_rise) begin
                     state_reg    <= FSS_RUN;
                     step_cnt_reg <= 12'h000;
                     freq_reg     <= start_frequency;
                  end
               end
               FSS_RUN: begin
                  if (step_now) begin
                     if (last) begin
                        state_reg <= FSS_IDLE;
                     end else begin
                        step_cnt_reg <= step_cnt_reg + 12'h001;
                        freq_reg     <= freq_reg + step_ext;
                        pulse_reg    <= 1'b1;
                     end
                  end
               end
               default: state_reg <= FSS_IDLE;
            endcase
         end
      end
   end

   // output flags; midscale whenever idle or aborted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= 1'b0;
         busy_reg   <= 1'b0;
      end else begin
         enable_reg <= (state_reg == FSS_RUN) & ~abort_rise & ~(step_now & last) & live;
         busy_reg   <= (state_reg == FSS_RUN) & ~abort_rise & ~(step_now & last);
      end
   end

   assign freq_word   = freq_reg;
   assign wave_enable = enable_reg;
   assign sweep_busy  = busy_reg;
   assign step_pulse  = pulse_reg;
endmodule // fss_device

/* tb/fss_properties.sv */
// fss_properties: wire checks on the serial command link between the two ends.
// assumes the bench top instantiates it beside the link, one pclk domain.
`timescale 1ns/100ps
module fss_properties #(
   parameter int HALF_CYC = fss_pkg::LINK_HALF_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic link_sclk,
   input wire logic link_sdata,
   input wire logic frame_select_n,
   input wire logic trigger,
   input wire logic abort
);
   // ------------------------------------------------------------
   // helper counters
   // ------------------------------------------------------------
   localparam int FRAME_CYC = 32 * HALF_CYC;  // sixteen bits of two halves
   logic [15:0] low_cnt_reg;
   logic [4:0]  fall_cnt_reg;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // cycles and sclk falls inside a frame; cleared while the frame is idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_reg  <= 16'h0000;
         fall_cnt_reg <= 5'h00;
      end else if (frame_select_n) begin
         low_cnt_reg  <= 16'h0000;
         fall_cnt_reg <= 5'h00;
      end else begin
         low_cnt_reg  <= low_cnt_reg + 16'h0001;
         fall_cnt_reg <= fall_cnt_reg + {4'h0, $fell(link_sclk)};
      end
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_sclk_idle_high: assert property (frame_select_n |-> link_sclk)
      else $error("sclk not high outside a frame");
   a_frame_length: assert property ($rose(frame_select_n) |-> low_cnt_reg == FRAME_CYC)
      else $error("frame length wrong");
   a_sixteen_falls: assert property ($rose(frame_select_n) |-> fall_cnt_reg == 5'h10)
      else $error("frame did not hold sixteen bits");
   a_first_bit_setup: assert property ($fell(frame_select_n) |-> link_sclk[*4] ##1 !link_sclk)
      else $error("first bit not set up a half period");
   a_sclk_low_half: assert property ($fell(link_sclk) |-> !link_sclk[*4] ##1 link_sclk)
      else $error("sclk low phase wrong");
   a_data_held_low: assert property ($fell(link_sclk) |-> $stable(link_sdata)[*4])
      else $error("data moved while sclk low");
   a_data_on_rise: assert property ($changed(link_sdata) && !frame_select_n
      && !$fell(frame_select_n) |-> $rose(link_sclk))
      else $error("data moved off the sclk rise");
   a_frame_gap: assert property ($rose(frame_select_n) |-> frame_select_n[*4])
      else $error("frames too close");
   c_frame_done: cover property ($rose(frame_select_n));
   c_trigger_rise: cover property ($rose(trigger));
   c_abort_rise: cover property ($rose(abort));
endmodule // fss_properties

/* tb/test_frequency_sweep_sequencer.sv */
// test_frequency_sweep_sequencer: host and device ends joined over one link.
// assumes package, link interface and both design ends are compiled first.
`timescale 1ns/100ps
module test_frequency_sweep_sequencer;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [23:0] start_frequency, freq_word;
   logic [22:0] step_value;
   logic        cont_sel, bsrc_sel, isrc_sel, wave_cycle_pulse, wave_on;
   logic        wave_enable, sweep_busy, step_pulse;
   logic [8:0]  mult [4] = '{fss_pkg::MULT_X1, fss_pkg::MULT_X5,
                             fss_pkg::MULT_X100, fss_pkg::MULT_X500};
   int          bad_count, checks, n_busy, n_en, n_step;
   fss_link_if link_a ();
   fss_host i_fss_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link_a));
   fss_device i_fss_device (.pclk(pclk), .presetn(presetn), .link(link_a),
      .start_frequency(start_frequency), .step_value(step_value),
      .continuous_or_burst_select(cont_sel), .burst_source_select(bsrc_sel),
      .increment_source_select(isrc_sel), .wave_cycle_pulse(wave_cycle_pulse),
      .freq_word(freq_word), .wave_enable(wave_enable), .sweep_busy(sweep_busy),
      .step_pulse(step_pulse));
   fss_properties #(.HALF_CYC(fss_pkg::LINK_HALF_CYC)) i_fss_properties (.pclk(pclk),
      .presetn(presetn), .link_sclk(link_a.link_sclk), .link_sdata(link_a.link_sdata),
      .frame_select_n(link_a.frame_select_n), .trigger(link_a.trigger),
      .abort(link_a.abort));
   // 25 ns clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // outcome tallies; wave pulse every second clock stands in for output cycles
   always @(posedge pclk) begin
      wave_cycle_pulse <= wave_on && !wave_cycle_pulse;
      if (sweep_busy === 1'b1) n_busy++;
      if (wave_enable === 1'b1) n_en++;
      if (step_pulse === 1'b1) n_step++;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task finish_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task fail_wait;
      bad_count++;
      $display("wrong value at %0t: wait ran out", $time);
      finish_test();
   endtask
   // one apb transfer, held until pready is seen high at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50 && pready !== 1'b1; i++) @(posedge pclk);
      if (i == 50) fail_wait();
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pins(input logic [1:0] v);
      apb(1'b1, fss_pkg::HOST_PINS_OFS, {30'h0, v});
   endtask
   // a second word written while the sender is busy would be dropped: poll first
   task send(input logic [15:0] w);
      int i;
      apb(1'b1, fss_pkg::HOST_CMD_OFS, {16'h0000, w});
      for (i = 0; i < 100; i++) begin
         apb(1'b0, fss_pkg::HOST_STATUS_OFS, 32'h0);
         if (q[0] === 1'b0) break;
      end
      if (i == 100) fail_wait();
   endtask
   task wait_busy(input logic lvl);
      int i;
      for (i = 0; i < 20000 && sweep_busy !== lvl; i++) @(posedge pclk);
      if (i == 20000) fail_wait();
   endtask
   // md is {continuous, burst source, increment source}
   task setup(input logic [11:0] n, input logic [15:0] wi, input logic [15:0] wb,
              input logic [2:0] md);
      send({4'h1, n});
      send(wi);
      send(wb);
      {cont_sel, bsrc_sel, isrc_sel} <= md;
      @(negedge pclk);
      n_busy = 0;
      n_en = 0;
      n_step = 0;
   endtask
   task auto_run;
      pins(2'h1);
      wait_busy(1'b1);
      chk(freq_word, start_frequency);
      wait_busy(1'b0);
      repeat (3) @(posedge pclk);
      pins(2'h0);
   endtask
   // each pin level lasts hi plus the four clocks of one apb write
   task pulses(input int hi);
      repeat (4) begin
         pins(2'h1);
         repeat (hi) @(posedge pclk);
         pins(2'h0);
         repeat (hi) @(posedge pclk);
      end
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      start_frequency = 24'h100000;
      step_value = 23'h7FFFF0;  // negative, so the sweep runs downwards
      {cont_sel, bsrc_sel, isrc_sel} = 3'b100;
      wave_on = 1'b0;
      wave_cycle_pulse = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, fss_pkg::HOST_STATUS_OFS, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk({q[30:0], err}, 32'h1);
      $display("test register map done");
      // busy rises a clock after the sweep starts, so it shows one cycle less
      for (int m = 0; m < 4; m++) begin
         setup(12'(m + 2), 16'h6002 | (16'(m) << 11), 16'hA001, 3'b100);
         auto_run();
         chk(n_busy, (m + 3) * 2 * mult[m] - 1);
         chk(n_step, m + 2);
         chk(n_en, n_busy);
         chk(freq_word, 24'(start_frequency + 24'(m + 2) * {step_value[22], step_value}));
      end
      $display("test auto sweep done");
      wave_on = 1'b1;
      setup(12'h002, 16'h4003, 16'hA001, 3'b100);
      auto_run();
      chk(n_step, 2);
      chk(n_busy > 14 && n_busy < 22, 1);
      wave_on = 1'b0;
      setup(12'h002, 16'h6004, 16'h9802, 3'b000);
      auto_run();
      chk(n_en, 6);
      chk(n_busy, 11);
      $display("test burst sweep done");
      setup(12'h002, 16'h4004, 16'hA003, 3'b001);
      pulses(8);
      chk(n_step, 2);
      chk(n_en, 9);
      chk(sweep_busy, 1'b0);
      setup(12'h002, 16'h5804, 16'h9804, 3'b011);
      pulses(8);
      // the first burst loses the clock in which the sweep starts
      chk(n_en, 35);
      chk(n_step, 2);
      $display("test external sweep done");
      setup(12'h005, 16'h7802, 16'hA001, 3'b100);
      pins(2'h1);
      wait_busy(1'b1);
      pins(2'h3);
      repeat (6) @(posedge pclk);
      chk({sweep_busy, wave_enable}, 32'h0);
      pins(2'h0);
      $display("test abort done");
      finish_test();
   end
endmodule // test_frequency_sweep_sequencer
